// ==== common/adc_sel_pkg.sv ====
`default_nettype none
package adc_sel_pkg;
    // ==========================================================
    // register map (byte addresses, one aligned word each)
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CHS123 = 8'h00;
    localparam logic [7:0] OFF_CHS0 = 8'h04;
    localparam logic [7:0] OFF_SCAN_HIGH = 8'h08;
    localparam logic [7:0] OFF_SCAN_LOW = 8'h0C;
    localparam logic [7:0] OFF_PIN_DIGITAL_CFG_HIGH = 8'h10;
    localparam logic [7:0] OFF_PIN_DIGITAL_CFG_LOW = 8'h14;
    localparam logic [7:0] OFF_PCFG2_LOW = 8'h18;
    localparam logic [7:0] OFF_CTRL = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [15:0] RST_REG = 16'h0000;

    // ==========================================================
    // channel 1-3 select fields
    // ==========================================================
    localparam int CH123_NB_LSB = 9;
    localparam int CH123_SB_BIT = 8;
    localparam int CH123_NA_LSB = 1;
    localparam int CH123_SA_BIT = 0;
    localparam logic [15:0] CH123_IMPL_MASK = 16'h0707;

    // ==========================================================
    // channel 0 select fields
    // ==========================================================
    localparam int CH0_NB_BIT = 15;
    localparam int CH0_SB_LSB = 8;
    localparam int CH0_NA_BIT = 7;
    localparam int CH0_SA_LSB = 0;
    localparam logic [15:0] CH0_IMPL_MASK = 16'h9F9F;

    // ==========================================================
    // control register fields
    // ==========================================================
    localparam int CTRL_MODE12_BIT = 0;
    localparam int CTRL_SCAN_BIT = 1;
    localparam logic [15:0] CTRL_IMPL_MASK = 16'h0003;

    // ==========================================================
    // input routing encodings
    // ==========================================================
    localparam logic [1:0] NEG_CODE_HIGH = 2'h3;
    localparam logic [1:0] NEG_CODE_MID = 2'h2;
    localparam logic [4:0] NEG_HIGH_BASE = 5'h09;
    localparam logic [4:0] NEG_MID_BASE = 5'h06;
    localparam logic [4:0] POS_HIGH_BASE = 5'h03;
    localparam logic [4:0] POS_LOW_BASE = 5'h00;
    localparam logic [4:0] CH0_NEG_INPUT = 5'h01;
    localparam int MAX_INPUTS = 32;
    localparam int LOW_INPUTS = 16;
endpackage
`default_nettype wire

// ==== common/adc_sel_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface adc_sel_if;
    // scan group
    logic [31:0] scanMask;
    logic scanRun;
    logic scanAdvance;
    logic [4:0] scanIdx;
    // pin configuration group
    logic [31:0] cfgConv1;
    logic [15:0] cfgConv2Low;
    logic [31:0] pinDigital;

    modport top (output scanMask, scanRun, scanAdvance, cfgConv1, cfgConv2Low, input scanIdx, pinDigital);
    modport scan (input scanMask, scanRun, scanAdvance, output scanIdx);
    modport pin (input cfgConv1, cfgConv2Low, output pinDigital);
endinterface
`default_nettype wire

// ==== rtl/scan_stepper.sv ====
`timescale 1ns/1ps
`default_nettype none
module scan_stepper (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // scan control and current input
    adc_sel_if.scan sel
);
    // ==========================================================
    // next selected input search
    // ==========================================================
    logic [4:0] scanIdx_r;
    logic [4:0] scanIdx_nxt;
    logic [4:0] firstIdx;
    logic [4:0] afterIdx;
    logic foundFirst;
    logic foundAfter;

    // lowest set bit, and lowest set bit above the current one
    always_comb
    begin
        firstIdx = 5'h00;
        foundFirst = 1'b0;
        for (int k = 0; k < adc_sel_pkg::MAX_INPUTS; k++)
        begin
            if (!foundFirst && sel.scanMask[k])
            begin
                firstIdx = 5'(k);
                foundFirst = 1'b1;
            end
        end
        afterIdx = firstIdx; // wrap to the lowest when nothing lies above, see [RULE15]
        foundAfter = 1'b0;
        for (int k = 0; k < adc_sel_pkg::MAX_INPUTS; k++)
        begin
            if (!foundAfter && sel.scanMask[k] && (5'(k) > scanIdx_r))
            begin
                afterIdx = 5'(k);
                foundAfter = 1'b1;
            end
        end
    end

    // idle scan parks on the lowest selected input; a step moves to the next selected input above, or wraps to the lowest
    always_comb
    begin
        if (!sel.scanRun)
            scanIdx_nxt = firstIdx;
        else if (sel.scanAdvance)
            scanIdx_nxt = afterIdx; // see [RULE15]
        else
            scanIdx_nxt = scanIdx_r;
    end

    // current scan position
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            scanIdx_r <= 5'h00;
        else
            scanIdx_r <= scanIdx_nxt;
    end

    assign sel.scanIdx = scanIdx_r;
endmodule
`default_nettype wire

// ==== rtl/pin_mode_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_mode_ctrl #(
    parameter int NUM_INPUTS = 32,
    parameter bit TWO_CONV = 1'b1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // configuration in, pin mode out
    adc_sel_if.pin sel
);
    // ==========================================================
    // per-pin digital/analog decision
    // ==========================================================
    logic [31:0] pinDigital_r;

    for (genvar i = 0; i < adc_sel_pkg::MAX_INPUTS; i++)
    begin : gPin
        logic dig_nxt;
        if (i >= NUM_INPUTS)
        begin : gAbsent
            // no analog input behind this port: the bit is stored but ignored
            assign dig_nxt = 1'b1; // see [RULE10]
        end
        else if (TWO_CONV && (i < adc_sel_pkg::LOW_INPUTS))
        begin : gShared
            // either converter may claim the shared pin as digital
            assign dig_nxt = sel.cfgConv1[i] | sel.cfgConv2Low[i]; // see [RULE12]
        end
        else
        begin : gSingle
            assign dig_nxt = sel.cfgConv1[i]; // see [RULE8] see [RULE9]
        end

        always_ff @(posedge mclk or negedge rst_n)
        begin
            if (!rst_n)
                pinDigital_r[i] <= 1'b0;
            else
                pinDigital_r[i] <= dig_nxt;
        end
    end

    assign sel.pinDigital = pinDigital_r;
endmodule
`default_nettype wire

// ==== rtl/adc_input_select.sv ====
// Contract
// [RULE1] channel 1-3 negative code picks AN9/AN6/reference
// [RULE2] channel 1-3 positive bit picks AN3.. or AN0..
// [RULE3] 12-bit mode: channel 1-3 fields read zero, ignore writes
// [RULE4] channel 0 negative bit set selects AN1
// [RULE5] channel 0 positive code n selects ANn
// [RULE6] 32-bit scan mask, set bit scans input
// [RULE7] mask always writable; absent input converts reference
// [RULE8] set config bit: digital, read enabled, mux grounded
// [RULE9] clear config bit: analog, read disabled, pin sampled
// [RULE10] all config bits writable; absent inputs unaffected
// [RULE11] second converter has only low config register
// [RULE12] shared pins follow both low config registers
// [RULE13] unimplemented select bits read as zero
// [RULE14] scanning drives channel 0 positive in sample A
// [RULE15] scan ascends selected inputs, wraps to lowest
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adc_input_select #(
    parameter int NUM_INPUTS = 32,
    parameter bit TWO_CONV = 1'b1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // conversion sequencer
    input wire logic sampleB,
    input wire logic scanAdvance,
    // channel 0 routing
    output logic [4:0] ch0PosIdx,
    output logic ch0PosNegRef,
    output logic [4:0] ch0NegIdx,
    output logic ch0NegRef,
    // channel 1-3 routing, entry 0 is channel 1
    output logic [2:0][4:0] ch123PosIdx,
    output logic [2:0][4:0] ch123NegIdx,
    output logic [2:0] ch123NegRef,
    // port pins
    output logic [31:0] pinDigital,
    output logic [31:0] portReadEn,
    output logic [31:0] muxGround
);
    // ==========================================================
    // elaboration checks
    if (NUM_INPUTS < 1 || NUM_INPUTS > adc_sel_pkg::MAX_INPUTS)
    begin : gBadInputs
        $error("NUM_INPUTS must lie between 1 and 32");
    end

    // ==========================================================
    // declarations
    adc_sel_if sel ();

    logic [15:0] chs123_r, chs0_r, scanHigh_r, scanLow_r, pcfgHigh_r, pcfgLow_r, pcfg2Low_r, ctrl_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic pslverr_nxt;
    logic wrEn;
    logic setupPhase;
    logic mode12;
    logic scanOn;
    logic [15:0] chs123View;
    logic [4:0] ch0PosIdx_r;
    logic [4:0] ch0PosIdx_nxt;
    logic ch0PosNegRef_r;
    logic ch0PosNegRef_nxt;
    logic [4:0] ch0NegIdx_r;
    logic ch0NegRef_r;
    logic ch0NegRef_nxt;
    logic [2:0][4:0] ch123PosIdx_r;
    logic [2:0][4:0] ch123PosIdx_nxt;
    logic [2:0][4:0] ch123NegIdx_r;
    logic [2:0][4:0] ch123NegIdx_nxt;
    logic [2:0] ch123NegRef_r;
    logic [2:0] ch123NegRef_nxt;
    logic negSelRaw;
    logic posSelRaw;
    logic [1:0] negCode;

    // ==========================================================
    // apb handshake
    // read data are captured in the setup cycle so prdata leaves a flop;
    // the price is one fixed access cycle on every transfer
    assign setupPhase = psel & ~penable;
    assign wrEn = psel & penable & pready_r & pwrite;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= setupPhase;
            pslverr_r <= setupPhase & pslverr_nxt;
            if (setupPhase)
                prdata_r <= pwrite ? 32'h0000_0000 : prdata_nxt;
        end
    end

    // ==========================================================
    // control and mode view
    assign mode12 = ctrl_r[adc_sel_pkg::CTRL_MODE12_BIT];
    assign scanOn = ctrl_r[adc_sel_pkg::CTRL_SCAN_BIT];
    // 12-bit mode hides the whole channel 1-3 register
    assign chs123View = mode12 ? 16'h0000 : (chs123_r & adc_sel_pkg::CH123_IMPL_MASK); // see [RULE3] see [RULE13]

    // ==========================================================
    // read decode
    always_comb
    begin
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        case (paddr)
            adc_sel_pkg::OFF_CHS123:
                prdata_nxt = {16'h0000, chs123View}; // see [RULE3]
            adc_sel_pkg::OFF_CHS0:
                prdata_nxt = {16'h0000, chs0_r & adc_sel_pkg::CH0_IMPL_MASK}; // see [RULE13]
            adc_sel_pkg::OFF_SCAN_HIGH:
                prdata_nxt = {16'h0000, scanHigh_r};
            adc_sel_pkg::OFF_SCAN_LOW:
                prdata_nxt = {16'h0000, scanLow_r};
            adc_sel_pkg::OFF_PIN_DIGITAL_CFG_HIGH:
                prdata_nxt = {16'h0000, pcfgHigh_r}; // see [RULE10]
            adc_sel_pkg::OFF_PIN_DIGITAL_CFG_LOW:
                prdata_nxt = {16'h0000, pcfgLow_r};
            adc_sel_pkg::OFF_PCFG2_LOW:
                prdata_nxt = {16'h0000, pcfg2Low_r}; // see [RULE11]
            adc_sel_pkg::OFF_CTRL:
                prdata_nxt = {16'h0000, ctrl_r};
            adc_sel_pkg::OFF_STATUS:
                prdata_nxt = {21'h0, ch0PosNegRef_r, sel.scanIdx, ch0PosIdx_r};
            default:
                pslverr_nxt = 1'b1;
        endcase
    end

    // ==========================================================
    // channel select registers
    // channel 1-3 writes are dropped while the 12-bit mode is on
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            chs123_r <= adc_sel_pkg::RST_REG;
        else if (wrEn && paddr == adc_sel_pkg::OFF_CHS123 && !mode12) // see [RULE3]
            chs123_r <= pwdata[15:0] & adc_sel_pkg::CH123_IMPL_MASK; // see [RULE13]
    end

    // channel 0 select register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            chs0_r <= adc_sel_pkg::RST_REG;
        else if (wrEn && paddr == adc_sel_pkg::OFF_CHS0)
            chs0_r <= pwdata[15:0] & adc_sel_pkg::CH0_IMPL_MASK; // see [RULE13]
    end

    // ==========================================================
    // scan mask registers
    // every bit is kept, whether or not the input exists
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scanHigh_r <= adc_sel_pkg::RST_REG;
            scanLow_r <= adc_sel_pkg::RST_REG;
        end
        else if (wrEn)
        begin
            if (paddr == adc_sel_pkg::OFF_SCAN_HIGH)
                scanHigh_r <= pwdata[15:0]; // see [RULE6] see [RULE7]
            if (paddr == adc_sel_pkg::OFF_SCAN_LOW)
                scanLow_r <= pwdata[15:0]; // see [RULE6] see [RULE7]
        end
    end

    // ==========================================================
    // pin configuration registers
    // the second converter owns only a low register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pcfgHigh_r <= adc_sel_pkg::RST_REG;
            pcfgLow_r <= adc_sel_pkg::RST_REG;
            pcfg2Low_r <= adc_sel_pkg::RST_REG;
        end
        else if (wrEn)
        begin
            if (paddr == adc_sel_pkg::OFF_PIN_DIGITAL_CFG_HIGH)
                pcfgHigh_r <= pwdata[15:0]; // see [RULE10] see [RULE11]
            if (paddr == adc_sel_pkg::OFF_PIN_DIGITAL_CFG_LOW)
                pcfgLow_r <= pwdata[15:0]; // see [RULE10]
            if (paddr == adc_sel_pkg::OFF_PCFG2_LOW)
                pcfg2Low_r <= pwdata[15:0]; // see [RULE11] see [RULE12]
        end
    end

    // ==========================================================
    // control register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_r <= adc_sel_pkg::RST_REG;
        else if (wrEn && paddr == adc_sel_pkg::OFF_CTRL)
            ctrl_r <= pwdata[15:0] & adc_sel_pkg::CTRL_IMPL_MASK;
    end

    // ==========================================================
    // submodule links
    assign sel.scanMask = {scanHigh_r, scanLow_r};
    assign sel.scanRun = scanOn;
    // a step only means something while the scan is on
    assign sel.scanAdvance = scanAdvance & scanOn;
    assign sel.cfgConv1 = {pcfgHigh_r, pcfgLow_r};
    assign sel.cfgConv2Low = TWO_CONV ? pcfg2Low_r : 16'h0000;

    scan_stepper uStep (
        .mclk(mclk),
        .rst_n(rst_n),
        .sel(sel.scan)
    );

    pin_mode_ctrl #(
        .NUM_INPUTS(NUM_INPUTS),
        .TWO_CONV(TWO_CONV)
    ) uPin (
        .mclk(mclk),
        .rst_n(rst_n),
        .sel(sel.pin)
    );

    // ==========================================================
    // channel 0 routing
    // scan overrides the fixed field only in sample A
    always_comb
    begin
        ch0PosNegRef_nxt = 1'b0;
        if (scanOn && !sampleB)
        begin
            ch0PosIdx_nxt = sel.scanIdx; // see [RULE14]
            ch0PosNegRef_nxt = (32'(sel.scanIdx) >= NUM_INPUTS); // see [RULE7]
        end
        else if (sampleB)
            ch0PosIdx_nxt = chs0_r[adc_sel_pkg::CH0_SB_LSB +: 5]; // see [RULE5]
        else
            ch0PosIdx_nxt = chs0_r[adc_sel_pkg::CH0_SA_LSB +: 5]; // see [RULE5]
        negSelRaw = sampleB ? chs0_r[adc_sel_pkg::CH0_NB_BIT] : chs0_r[adc_sel_pkg::CH0_NA_BIT];
        ch0NegRef_nxt = ~negSelRaw; // see [RULE4]
    end

    // ==========================================================
    // channel 1-3 routing
    // the hidden fields decode as zero: reference and AN0..AN2
    always_comb
    begin
        posSelRaw = sampleB ? chs123View[adc_sel_pkg::CH123_SB_BIT] : chs123View[adc_sel_pkg::CH123_SA_BIT];
        negCode = sampleB ? chs123View[adc_sel_pkg::CH123_NB_LSB +: 2] : chs123View[adc_sel_pkg::CH123_NA_LSB +: 2];
        for (int c = 0; c < 3; c++)
        begin
            ch123PosIdx_nxt[c] = (posSelRaw ? adc_sel_pkg::POS_HIGH_BASE : adc_sel_pkg::POS_LOW_BASE)
                                 + 5'(c); // see [RULE2]
            ch123NegRef_nxt[c] = 1'b0;
            if (negCode == adc_sel_pkg::NEG_CODE_HIGH)
                ch123NegIdx_nxt[c] = adc_sel_pkg::NEG_HIGH_BASE + 5'(c); // see [RULE1]
            else if (negCode == adc_sel_pkg::NEG_CODE_MID)
                ch123NegIdx_nxt[c] = adc_sel_pkg::NEG_MID_BASE + 5'(c); // see [RULE1]
            else
            begin
                ch123NegIdx_nxt[c] = 5'h00;
                ch123NegRef_nxt[c] = 1'b1; // see [RULE1]
            end
        end
    end

    // ==========================================================
    // routing output flops
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch0PosIdx_r <= 5'h00;
            ch0PosNegRef_r <= 1'b0;
            ch0NegIdx_r <= 5'h00;
            ch0NegRef_r <= 1'b1;
            ch123PosIdx_r <= '0;
            ch123NegIdx_r <= '0;
            ch123NegRef_r <= 3'h7;
        end
        else
        begin
            ch0PosIdx_r <= ch0PosIdx_nxt;
            ch0PosNegRef_r <= ch0PosNegRef_nxt;
            ch0NegIdx_r <= ch0NegRef_nxt ? 5'h00 : adc_sel_pkg::CH0_NEG_INPUT; // see [RULE4]
            ch0NegRef_r <= ch0NegRef_nxt;
            ch123PosIdx_r <= ch123PosIdx_nxt;
            ch123NegIdx_r <= ch123NegIdx_nxt;
            ch123NegRef_r <= ch123NegRef_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign ch0PosIdx = ch0PosIdx_r;
    assign ch0PosNegRef = ch0PosNegRef_r;
    assign ch0NegIdx = ch0NegIdx_r;
    assign ch0NegRef = ch0NegRef_r;
    assign ch123PosIdx = ch123PosIdx_r;
    assign ch123NegIdx = ch123NegIdx_r;
    assign ch123NegRef = ch123NegRef_r;
    // one pin-mode flop drives mode, read path and mux grounding together
    assign pinDigital = sel.pinDigital; // see [RULE8] see [RULE9]
    assign portReadEn = sel.pinDigital; // see [RULE8] see [RULE9]
    assign muxGround = sel.pinDigital; // see [RULE8]
endmodule
`default_nettype wire

// ==== verif/adc_sel_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_sel_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // routing and pins
    input wire logic [4:0] ch0NegIdx,
    input wire logic ch0NegRef,
    input wire logic [31:0] pinDigital
);
    // ======================
    // helpers
    // ======================
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic rdAcc;
    logic mode_r;
    // completed read in this cycle
    assign rdAcc = psel && penable && pready && !pwrite;
    // mirror of the mode bit, so hidden reads can be judged
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            mode_r <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == 8'h1C)
            mode_r <= pwdata[0];
    end
    // ======================
    // properties
    // ======================
    sequence s_setup; psel && !penable; endsequence
    sequence s_answer; pready ##1 !pready; endsequence
    property p_ready_pulse; s_setup |=> s_answer; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("answer not one cycle after setup");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_unmapped; psel && penable && pready && paddr > 8'h20 |-> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_hide12; rdAcc && paddr == 8'h00 && mode_r |-> prdata == 32'h0; endproperty
    a_hide12: assert property (p_hide12) else $error("channel 1-3 fields visible in 12-bit mode");
    property p_res123; rdAcc && paddr == 8'h00 |-> (prdata & ~32'h0707) == 32'h0; endproperty
    a_res123: assert property (p_res123) else $error("reserved channel 1-3 bits set");
    property p_res0; rdAcc && paddr == 8'h04 |-> (prdata & ~32'h9F9F) == 32'h0; endproperty
    a_res0: assert property (p_res0) else $error("reserved channel 0 bits set");
    property p_pin_digital_cfg_set;
        psel && penable && pready && pwrite && paddr == 8'h14
            |-> ##2 ((pinDigital & $past(pwdata, 2)) & 32'hFFFF) == ($past(pwdata, 2) & 32'hFFFF);
    endproperty
    a_pin_digital_cfg_set: assert property (p_pin_digital_cfg_set) else $error("set config bit left pin analog");
    property p_ch0neg; ch0NegIdx == (ch0NegRef ? 5'h00 : 5'h01); endproperty
    a_ch0neg: assert property (p_ch0neg) else $error("channel 0 negative input wrong");
endmodule
bind adc_input_select adc_sel_checker adc_sel_checker_i (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ch0NegIdx, .ch0NegRef, .pinDigital);
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ======================
    // design hookup
    // ======================
    localparam int NI = 24;
    logic mclk, rst_n, psel, penable, pwrite, sampleB, scanAdvance, pready, pslverr, ch0PosNegRef, ch0NegRef;
    logic rerr, mode12;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, pinDigital, portReadEn, muxGround, rdat, w, mask, c2;
    logic [4:0] ch0PosIdx, ch0NegIdx;
    logic [2:0][4:0] ch123PosIdx, ch123NegIdx;
    logic [2:0] ch123NegRef;
    logic [15:0] m123, m0;
    int checks, mismatches, cyc, idx;
    adc_input_select #(.NUM_INPUTS(NI)) adc_input_select_i (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sampleB, .scanAdvance, .ch0PosIdx, .ch0PosNegRef, .ch0NegIdx,
        .ch0NegRef, .ch123PosIdx, .ch123NegIdx, .ch123NegRef, .pinDigital, .portReadEn, .muxGround);
    // clock, 5 ns period
    always #2.5 mclk = ~mclk;
    // hang guard, far above the real run length
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            finish_test;
        end
    end
    // ======================
    // tasks
    // ======================
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    // model of the routing with scan off
    task automatic chk_route;
        logic [2:0] f;
        f = mode12 ? 3'h0 : (sampleB ? m123[10:8] : m123[2:0]);
        for (int c = 0; c < 3; c++)
        begin
            chk("pos", 32'(ch123PosIdx[c]), 32'(f[0] ? 3 + c : c));
            chk("nref", 32'(ch123NegRef[c]), 32'(!f[2]));
            chk("neg", 32'(ch123NegIdx[c]), 32'(f[2] ? (f[1] ? 9 : 6) + c : 0));
        end
        chk("c0pos", 32'(ch0PosIdx), 32'(sampleB ? m0[12:8] : m0[4:0]));
        chk("c0nref", 32'(ch0NegRef), 32'(!(sampleB ? m0[15] : m0[7])));
        chk("c0neg", 32'(ch0NegIdx), 32'(sampleB ? m0[15] : m0[7]));
    endtask
    function automatic int nxt(input int cur);
        for (int i = 1; i <= 32; i++)
            if (mask[(cur + i) % 32])
                return (cur + i) % 32;
        return cur;
    endfunction
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ======================
    // tests
    // ======================
    initial
    begin
        {mclk, rst_n, psel, penable, pwrite, sampleB, scanAdvance, mode12} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {m123, m0} = '0;
        void'($urandom(32'h0EAB));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (int a = 0; a <= 32; a += 4)
        begin
            apb(1'b0, 8'(a), 32'h0);
            chk("reset_rd", rdat, 32'h0);
        end
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped", 32'(rerr), 32'h1);
        chk_route;
        $display("test reset done");
        // every channel 1-3 code, channel 0 codes swept, reserved bits random
        for (int v = 0; v < 64; v++)
        begin
            w = ($urandom & 32'hFFFFF8F8) | 32'(v[2:0]) | (32'(v[5:3]) << 8);
            m123 = w[15:0] & 16'h0707;
            apb(1'b1, 8'h00, w);
            apb(1'b0, 8'h00, 32'h0);
            chk("chs123_rd", rdat, 32'(m123));
            w = $urandom;
            w[4:0] = v[4:0];
            w[12:8] = 5'(31 - v);
            m0 = w[15:0] & 16'h9F9F;
            apb(1'b1, 8'h04, w);
            apb(1'b0, 8'h04, 32'h0);
            chk("chs0_rd", rdat, 32'(m0));
            for (int b = 0; b < 2; b++)
            begin
                sampleB <= b[0];
                repeat (2) @(posedge mclk);
                chk_route;
            end
        end
        apb(1'b1, 8'h1C, 32'h1);
        mode12 = 1'b1;
        apb(1'b1, 8'h00, 32'h0202);
        apb(1'b0, 8'h00, 32'h0);
        chk("hidden", rdat, 32'h0);
        chk_route;
        apb(1'b1, 8'h1C, 32'h0);
        mode12 = 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        chk("unhidden", rdat, 32'(m123));
        $display("test routing done");
        // scan with a mask that reaches inputs the part lacks
        mask = ($urandom & $urandom) | 32'h80000001;
        apb(1'b1, 8'h08, {16'h0, mask[31:16]});
        apb(1'b1, 8'h0C, {16'h0, mask[15:0]});
        apb(1'b0, 8'h08, 32'h0);
        chk("scan_hi", rdat, {16'h0, mask[31:16]});
        apb(1'b1, 8'h1C, 32'h2);
        sampleB <= 1'b0;
        idx = 0;
        for (int k = 0; k < 16; k++)
        begin
            repeat (2) @(posedge mclk);
            chk("scan_pos", 32'(ch0PosIdx), 32'(idx));
            chk("scan_ref", 32'(ch0PosNegRef), 32'(idx >= NI));
            scanAdvance <= 1'b1;
            @(posedge mclk);
            scanAdvance <= 1'b0;
            idx = nxt(idx);
        end
        apb(1'b1, 8'h1C, 32'h0);
        $display("test scan done");
        // pin modes from both converters' settings
        for (int i = 0; i < 4; i++)
        begin
            w = (i == 3) ? $urandom : 32'h0;
            mask = i[1] ? $urandom : 32'h0;
            c2 = i[0] ? $urandom : 32'h0;
            apb(1'b1, 8'h10, w);
            apb(1'b1, 8'h14, mask);
            apb(1'b1, 8'h18, c2);
            apb(1'b0, 8'h18, 32'h0);
            chk("pcfg2_rd", rdat, {16'h0, c2[15:0]});
            repeat (2) @(posedge mclk);
            w = {w[15:0], mask[15:0] | c2[15:0]} | ({32{1'b1}} << NI);
            chk("pin_dig", pinDigital, w);
            chk("read_en", portReadEn, w);
            chk("mux_gnd", muxGround, w);
        end
        $display("test pins done");
        finish_test;
    end
endmodule
`default_nettype wire
